// file: shared/ars_map.svh
`ifndef ARS_MAP_SVH
`define ARS_MAP_SVH

// Time base.
`define ARS_CLK_PERIOD_NS  4
`define ARS_TICK_PERIOD_NS 1000000
`define ARS_TICK_CYCLES    (`ARS_TICK_PERIOD_NS / `ARS_CLK_PERIOD_NS)

// Register offsets (byte addresses).
`define ARS_OFF_CTRL      8'h00
`define ARS_OFF_ACT       8'h04
`define ARS_OFF_CLOSE     8'h08
`define ARS_OFF_RECLAIM   8'h0C
`define ARS_OFF_DEAD_BASE 8'h20
`define ARS_OFF_STATUS    8'h40
`define ARS_OFF_IRQ_STAT  8'h44
`define ARS_OFF_IRQ_MASK  8'h48

// Control field positions.
`define ARS_CTRL_SRC_BIT    0
`define ARS_CTRL_MON_BIT    1
`define ARS_CTRL_PICKUP_BIT 2
`define ARS_CTRL_LAST_LO    4
`define ARS_CTRL_LAST_HI    5

// Interrupt status bit positions.
`define ARS_IRQ_SUCCESS 0
`define ARS_IRQ_FINAL   1
`define ARS_IRQ_BLOCK   2
`define ARS_IRQ_CLOSE   3

// Reset values.
`define ARS_RST_CTRL    32'h0000_0035
`define ARS_RST_ACT     16'h01F4
`define ARS_RST_CLOSE   16'h0064
`define ARS_RST_RECLAIM 16'h07D0
`define ARS_RST_DEAD    16'h01F4
`define ARS_RST_MASK    4'h0

`endif

// file: shared/ars_pkg.sv
package ars_pkg;

  // Sequencer states.
  typedef enum logic [3:0] {
    S_IDLE, S_ACTION, S_TRIPPED, S_DEAD, S_RECLAIM,
    S_PEND, S_FINAL, S_DYN_BLOCK, S_NOT_READY
  } ars_state_e;

  // Synchronised pin inputs.
  typedef struct packed {
    logic pickup;
    logic trip;
    logic breaker_open;
    logic earth_fault;
  } ars_pins_s;

  // Control settings.
  typedef struct packed {
    logic       start_source_select;
    logic       breaker_state_monitor_en;
    logic       pickup_en;
    logic [1:0] last_shot;
  } ars_cfg_s;

endpackage : ars_pkg

// file: hdl/ars_sequencer.sv
`timescale 1ns/1ps
`include "ars_map.svh"

module ars_sequencer #(
  parameter int TICK_CYCLES = `ARS_TICK_CYCLES
) (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  input  wire logic        protection_pickup_in,
  input  wire logic        trip_in,
  input  wire logic        breaker_open_in,
  input  wire logic        earth_fault_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rdata_out,
  output logic             close_cmd_out,
  output logic             final_trip_out,
  output logic             blocked_out,
  output logic             in_progress_out,
  output logic             irq_out
);

  localparam int TW = $clog2(TICK_CYCLES + 1);

  ars_pkg::ars_state_e state_ff, nxt_state;
  logic [3:0]      sync1_ff, sync2_ff;
  ars_pkg::ars_pins_s pins;
  logic [TW-1:0]   tick_cnt_ff;
  logic            tick;
  logic [31:0]     ctrl_ff;
  ars_pkg::ars_cfg_s cfg;
  logic [15:0]     act_ff, close_t_ff, reclaim_ff;
  logic [15:0]     dead_ff [8];
  logic [3:0]      irq_stat_ff, irq_mask_ff, ev;
  logic [15:0]     tmr_ff, cl_tmr_ff, dead_sel;
  logic [1:0]      shot_ff, nxt_shot;
  logic            earth_ff, nxt_earth, pend_ff, nxt_pend;
  logic            close_ff, nxt_close, final_ff, blocked_ff, inprog_ff;
  logic            start_cond, fault, last_shot, act_done, dead_done;
  logic            close_done, reclaim_done, not_ready_cond, start_close;
  logic            hit_ctrl, hit_act, hit_close, hit_rec, hit_dead;
  logic            hit_stat, hit_irq, hit_mask;
  logic [31:0]     rd_mux;
  logic [2:0]      dead_idx;

  // Pins come from the protection side asynchronously: two flops each.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      sync1_ff <= 4'h0;
      sync2_ff <= 4'h0;
    end else begin
      sync1_ff <= {protection_pickup_in, trip_in, breaker_open_in,
                   earth_fault_in};
      sync2_ff <= sync1_ff;
    end
  end
  assign pins = sync2_ff;

  // Millisecond tick shared by every timer of the block.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || tick) begin
      tick_cnt_ff <= '0;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + TW'(1);
    end
  end
  assign tick = (tick_cnt_ff == TW'(TICK_CYCLES - 1));

  // Register address decode.
  assign hit_ctrl  = (addr_in == `ARS_OFF_CTRL);
  assign hit_act   = (addr_in == `ARS_OFF_ACT);
  assign hit_close = (addr_in == `ARS_OFF_CLOSE);
  assign hit_rec   = (addr_in == `ARS_OFF_RECLAIM);
  assign hit_dead  = (addr_in[7:5] == 3'(`ARS_OFF_DEAD_BASE >> 5))
                     && (addr_in[1:0] == 2'b00);
  assign hit_stat  = (addr_in == `ARS_OFF_STATUS);
  assign hit_irq   = (addr_in == `ARS_OFF_IRQ_STAT);
  assign hit_mask  = (addr_in == `ARS_OFF_IRQ_MASK);

  // Settings view of the control register.
  assign cfg.start_source_select      = ctrl_ff[`ARS_CTRL_SRC_BIT];
  assign cfg.breaker_state_monitor_en = ctrl_ff[`ARS_CTRL_MON_BIT];
  assign cfg.pickup_en                = ctrl_ff[`ARS_CTRL_PICKUP_BIT];
  assign cfg.last_shot = ctrl_ff[`ARS_CTRL_LAST_HI:`ARS_CTRL_LAST_LO];

  // Software settings. Changing them mid-sequence takes effect at once.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ctrl_ff     <= `ARS_RST_CTRL;
      act_ff      <= `ARS_RST_ACT;
      close_t_ff  <= `ARS_RST_CLOSE;
      reclaim_ff  <= `ARS_RST_RECLAIM;
      irq_mask_ff <= `ARS_RST_MASK;
      for (int i = 0; i < 8; i++) begin
        dead_ff[i] <= `ARS_RST_DEAD;
      end
    end else if (wr_in) begin
      if (hit_ctrl) ctrl_ff <= wdata_in & 32'h0000_0037;
      if (hit_act) act_ff <= wdata_in[15:0];
      if (hit_close) close_t_ff <= wdata_in[15:0];
      if (hit_rec) reclaim_ff <= wdata_in[15:0];
      if (hit_mask) irq_mask_ff <= wdata_in[3:0];
      if (hit_dead) dead_ff[addr_in[4:2]] <= wdata_in[15:0];
    end
  end

  // Sticky events; an event in the clearing cycle survives the clear.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      irq_stat_ff <= 4'h0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~((wr_in && hit_irq) ? wdata_in[3:0]
                                                          : 4'h0)) | ev;
    end
  end
  assign irq_out = |(irq_stat_ff & irq_mask_ff);

  // Read data: a mapped register, or zero for any other address.
  assign rd_mux = hit_ctrl  ? ctrl_ff :
                  hit_act   ? {16'h0000, act_ff} :
                  hit_close ? {16'h0000, close_t_ff} :
                  hit_rec   ? {16'h0000, reclaim_ff} :
                  hit_dead  ? {16'h0000, dead_ff[addr_in[4:2]]} :
                  hit_stat  ? {20'h0_0000, blocked_ff, final_ff, inprog_ff,
                               close_ff, 2'b00, shot_ff, 4'(state_ff)} :
                  hit_irq   ? {28'h000_0000, irq_stat_ff} :
                  hit_mask  ? {28'h000_0000, irq_mask_ff} : 32'h0000_0000;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      rdata_out <= 32'h0000_0000;
    end else begin
      rdata_out <= rd_in ? rd_mux : 32'h0000_0000;
    end
  end

  // Sequence conditions.
  assign fault      = pins.trip;
  assign last_shot  = (shot_ff == cfg.last_shot);
  assign start_cond = cfg.start_source_select ? pins.breaker_open
                                              : !pins.trip;
  assign dead_idx   = {shot_ff, earth_ff};
  assign dead_sel   = dead_ff[dead_idx];
  assign act_done   = (tmr_ff >= act_ff);
  assign dead_done  = (tmr_ff >= dead_sel);
  assign close_done = (cl_tmr_ff >= close_t_ff);
  // Only a fault can end reclaim while the close pulse is still out.
  assign reclaim_done = (tmr_ff >= reclaim_ff) && !close_ff;
  assign not_ready_cond = cfg.start_source_select && pins.breaker_open
                          && cfg.breaker_state_monitor_en;
  assign start_close = (state_ff == ars_pkg::S_DEAD)
                       && (nxt_state == ars_pkg::S_RECLAIM);

  // Next state, shot counter and fault type latch.
  always_comb begin
    nxt_state = state_ff;
    nxt_shot  = shot_ff;
    nxt_earth = earth_ff;
    nxt_pend  = pend_ff;
    ev        = 4'h0;
    case (state_ff)
      ars_pkg::S_IDLE: begin
        nxt_shot = 2'b00;
        if (fault) begin
          nxt_state = ars_pkg::S_TRIPPED;
        end else if (pins.pickup && cfg.pickup_en) begin
          nxt_state = ars_pkg::S_ACTION;
        end
      end
      ars_pkg::S_ACTION: begin
        if (fault) begin
          nxt_state = ars_pkg::S_TRIPPED;
        end else if (act_done) begin
          nxt_state = ars_pkg::S_DYN_BLOCK;
        end
      end
      ars_pkg::S_TRIPPED: begin
        if (pins.trip) nxt_earth = pins.earth_fault;
        if (start_cond) nxt_state = ars_pkg::S_DEAD;
      end
      ars_pkg::S_DEAD: begin
        if (fault) begin
          nxt_state = ars_pkg::S_FINAL;
        end else if (dead_done) begin
          nxt_state = ars_pkg::S_RECLAIM;
          nxt_pend  = 1'b0;
        end
      end
      ars_pkg::S_RECLAIM, ars_pkg::S_PEND: begin
        if (state_ff == ars_pkg::S_RECLAIM && pins.pickup && cfg.pickup_en)
          nxt_pend = 1'b1;
        if (fault) begin
          if (last_shot) begin
            nxt_state = ars_pkg::S_FINAL;
          end else begin
            nxt_state = ars_pkg::S_TRIPPED;
            nxt_shot  = shot_ff + 2'b01;
          end
        end else if (state_ff == ars_pkg::S_RECLAIM) begin
          if (reclaim_done && (pend_ff || nxt_pend)) begin
            nxt_state = ars_pkg::S_PEND;
          end else if (reclaim_done) begin
            nxt_state = ars_pkg::S_IDLE;
            ev[`ARS_IRQ_SUCCESS] = 1'b1;
          end
        end else if (!pins.pickup) begin
          nxt_state = ars_pkg::S_IDLE;
          ev[`ARS_IRQ_SUCCESS] = 1'b1;
        end else if (act_done) begin
          nxt_state = ars_pkg::S_DYN_BLOCK;
        end
      end
      ars_pkg::S_FINAL: begin
        nxt_state = ars_pkg::S_DYN_BLOCK;
      end
      ars_pkg::S_DYN_BLOCK: begin
        if (not_ready_cond) begin
          nxt_state = ars_pkg::S_NOT_READY;
        end else if (tmr_ff >= reclaim_ff) begin
          nxt_state = ars_pkg::S_IDLE;
        end
      end
      ars_pkg::S_NOT_READY: begin
        // Trips are ignored here; only a closed breaker ends the wait.
        if (!pins.breaker_open) nxt_state = ars_pkg::S_IDLE;
      end
      default: begin
        nxt_state = ars_pkg::S_IDLE;
      end
    endcase
    if (nxt_state == ars_pkg::S_FINAL) ev[`ARS_IRQ_FINAL] = 1'b1;
    if (nxt_state == ars_pkg::S_DYN_BLOCK && state_ff != ars_pkg::S_DYN_BLOCK)
      ev[`ARS_IRQ_BLOCK] = 1'b1;
    if (start_close) ev[`ARS_IRQ_CLOSE] = 1'b1;
  end

  // Close pulse: starts with reclaim, ends by its own timer or when reclaim is left.
  assign nxt_close = start_close ||
                     (close_ff && !close_done
                      && nxt_state == ars_pkg::S_RECLAIM);

  // State, timers and registered outputs.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_ff  <= ars_pkg::S_IDLE;
      tmr_ff    <= 16'h0000;
      cl_tmr_ff <= 16'h0000;
      shot_ff   <= 2'b00;
      earth_ff  <= 1'b0;
      pend_ff   <= 1'b0;
      close_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      shot_ff  <= nxt_shot;
      earth_ff <= nxt_earth;
      pend_ff  <= nxt_pend;
      close_ff <= nxt_close;
      if (nxt_state != state_ff) begin
        tmr_ff <= 16'h0000;
      end else if (tick && tmr_ff != 16'hFFFF) begin
        tmr_ff <= tmr_ff + 16'h0001;
      end
      if (start_close) begin
        cl_tmr_ff <= 16'h0000;
      end else if (tick && close_ff) begin
        cl_tmr_ff <= cl_tmr_ff + 16'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      final_ff   <= 1'b0;
      blocked_ff <= 1'b0;
      inprog_ff  <= 1'b0;
    end else begin
      final_ff   <= (nxt_state == ars_pkg::S_FINAL);
      blocked_ff <= (nxt_state == ars_pkg::S_DYN_BLOCK)
                    || (nxt_state == ars_pkg::S_NOT_READY);
      inprog_ff  <= (nxt_state == ars_pkg::S_TRIPPED)
                    || (nxt_state == ars_pkg::S_DEAD)
                    || (nxt_state == ars_pkg::S_RECLAIM)
                    || (nxt_state == ars_pkg::S_PEND);
    end
  end

  assign close_cmd_out   = close_ff;
  assign final_trip_out  = final_ff;
  assign blocked_out     = blocked_ff;
  assign in_progress_out = inprog_ff;

  // Checks on the sequence.
  property p_action_block;
    @(posedge ref_clk_in) disable iff (rst_in)
    (state_ff == ars_pkg::S_ACTION && !fault && act_done)
      |=> (state_ff == ars_pkg::S_DYN_BLOCK) ##1 blocked_out;
  endproperty
  a_action_block: assert property (p_action_block)
    else $error("Action timeout did not block.");

  property p_start_dead;
    @(posedge ref_clk_in) disable iff (rst_in)
    (state_ff == ars_pkg::S_TRIPPED && start_cond)
      |=> (state_ff == ars_pkg::S_DEAD && tmr_ff == 16'h0000);
  endproperty
  a_start_dead: assert property (p_start_dead)
    else $error("Start condition did not start dead time.");

  property p_dead_hold;
    @(posedge ref_clk_in) disable iff (rst_in)
    (state_ff == ars_pkg::S_DEAD && !fault && tmr_ff < dead_sel)
      |=> (state_ff == ars_pkg::S_DEAD) && !close_cmd_out;
  endproperty
  a_dead_hold: assert property (p_dead_hold)
    else $error("Dead time ended early.");

  property p_close_pulse;
    @(posedge ref_clk_in) disable iff (rst_in)
    (state_ff == ars_pkg::S_DEAD && !fault && dead_done)
      |=> close_cmd_out && !$past(close_cmd_out) && in_progress_out;
  endproperty
  a_close_pulse: assert property (p_close_pulse)
    else $error("No close pulse at dead time expiry.");

  property p_reclaim_covers_close;
    @(posedge ref_clk_in) disable iff (rst_in)
    (state_ff == ars_pkg::S_RECLAIM && close_cmd_out && !fault)
      |=> (state_ff == ars_pkg::S_RECLAIM);
  endproperty
  a_reclaim_covers_close: assert property (p_reclaim_covers_close)
    else $error("Reclaim ended while close pulse was out.");

  property p_next_cycle;
    @(posedge ref_clk_in) disable iff (rst_in)
    (state_ff == ars_pkg::S_RECLAIM && fault && !last_shot)
      |=> (state_ff == ars_pkg::S_TRIPPED)
          && (shot_ff == $past(shot_ff) + 2'b01);
  endproperty
  a_next_cycle: assert property (p_next_cycle)
    else $error("Fault in reclaim did not advance the cycle.");

  property p_success;
    @(posedge ref_clk_in) disable iff (rst_in)
    (state_ff == ars_pkg::S_RECLAIM && !fault && reclaim_done
     && !pend_ff && !nxt_pend)
      |=> (state_ff == ars_pkg::S_IDLE) ##1 (shot_ff == 2'b00);
  endproperty
  a_success: assert property (p_success)
    else $error("Quiet reclaim expiry did not reset.");

  property p_final_last;
    @(posedge ref_clk_in) disable iff (rst_in)
    (state_ff == ars_pkg::S_RECLAIM && fault && last_shot)
      |=> final_trip_out ##1 (blocked_out && !final_trip_out);
  endproperty
  a_final_last: assert property (p_final_last)
    else $error("Trip after last cycle missed final trip.");

  property p_final_dead;
    @(posedge ref_clk_in) disable iff (rst_in)
    (state_ff == ars_pkg::S_DEAD && fault) |=> final_trip_out;
  endproperty
  a_final_dead: assert property (p_final_dead)
    else $error("Fault in dead time missed final trip.");

  property p_not_ready;
    @(posedge ref_clk_in) disable iff (rst_in)
    (state_ff == ars_pkg::S_DYN_BLOCK && not_ready_cond)
      |=> (state_ff == ars_pkg::S_NOT_READY) && blocked_out
          && !in_progress_out;
  endproperty
  a_not_ready: assert property (p_not_ready)
    else $error("Blocked breaker-open case missed not ready.");

  property p_no_mon;
    @(posedge ref_clk_in) disable iff (rst_in)
    (state_ff == ars_pkg::S_DYN_BLOCK && !cfg.breaker_state_monitor_en)
      |=> (state_ff != ars_pkg::S_NOT_READY);
  endproperty
  a_no_mon: assert property (p_no_mon)
    else $error("Not ready entered with monitoring off.");

  property p_not_ready_blocked;
    @(posedge ref_clk_in) disable iff (rst_in)
    (state_ff == ars_pkg::S_NOT_READY && pins.breaker_open)
      |=> blocked_out && !close_cmd_out;
  endproperty
  a_not_ready_blocked: assert property (p_not_ready_blocked)
    else $error("Not ready without blocked output.");

  c_success: cover property (@(posedge ref_clk_in) disable iff (rst_in)
    state_ff == ars_pkg::S_RECLAIM ##1 state_ff == ars_pkg::S_IDLE);
  c_second_shot: cover property (@(posedge ref_clk_in)
    disable iff (rst_in) state_ff == ars_pkg::S_DEAD && shot_ff == 2'b01);
  c_not_ready: cover property (@(posedge ref_clk_in) disable iff (rst_in)
    state_ff == ars_pkg::S_NOT_READY);
  c_pend: cover property (@(posedge ref_clk_in) disable iff (rst_in)
    state_ff == ars_pkg::S_PEND ##1 state_ff == ars_pkg::S_TRIPPED);

endmodule : ars_sequencer

// file: bench/ars_far_side.sv
`timescale 1ns/1ps
// Relay and breaker seen from the sequencer. The trip trails its request by
// three cycles; a prompt breaker opens as the trip resets, a slow one three cycles later. The breaker closes
// on the close command unless it is held stuck, or by hand when the stuck
// hold is lifted.
module ars_far_side (
  input  wire logic ref_clk_in,
  input  wire logic pick_req_in,
  input  wire logic trip_req_in,
  input  wire logic earth_req_in,
  input  wire logic stuck_in,
  input  wire logic slow_in,
  input  wire logic close_cmd_in,
  output logic      pickup_out,
  output logic      trip_out,
  output logic      breaker_open_out,
  output logic      earth_out
);
  logic [5:0] trip_dly_ff = '0;
  logic       stuck_ff    = 1'b0;
  logic [3:0] pins_ff     = '0;
  wire        trip_gone;

  // A slow breaker opens three cycles later than a prompt one.
  assign trip_gone = slow_in ? (trip_dly_ff[5] & ~trip_dly_ff[4])
                             : (trip_dly_ff[2] & ~trip_dly_ff[1]);

  // Pickup covers the whole trip, so it never drops before the trip does.
  always @(posedge ref_clk_in) begin
    trip_dly_ff <= {trip_dly_ff[4:0], trip_req_in};
    stuck_ff    <= stuck_in;
    pins_ff[3]  <= pick_req_in | trip_req_in | (|trip_dly_ff[1:0]);
    pins_ff[2]  <= trip_dly_ff[1];
    pins_ff[0]  <= earth_req_in;
    if (trip_gone)
      pins_ff[1] <= 1'b1;
    else if ((close_cmd_in && !stuck_in) || (stuck_ff && !stuck_in))
      pins_ff[1] <= 1'b0;
  end

  assign {pickup_out, trip_out, breaker_open_out, earth_out} = pins_ff;
endmodule : ars_far_side

// file: bench/ars_sequencer_test.sv
`timescale 1ns/1ps
module ars_sequencer_test;
  localparam int T = 8;
  localparam int C = 3;
  logic        ref_clk_in, rst_in, wr_in, rd_in;
  logic [7:0]  addr_in;
  logic [31:0] wdata_in, rdata_out, rd_v, lfsr;
  logic        close_cmd_out, final_trip_out, blocked_out;
  logic        in_progress_out, irq_out;
  logic        pick_req, trip_req, earth_req, stuck, slow;
  logic        pick_w, trip_w, brk_w, earth_w;
  int          n_mismatch, checked, cyc, n_final, n_close, n, f0, c0, r;
  int          dt [8];

  ars_sequencer #(.TICK_CYCLES(T)) i_ars_sequencer (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .protection_pickup_in(pick_w), .trip_in(trip_w),
    .breaker_open_in(brk_w), .earth_fault_in(earth_w),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .close_cmd_out(close_cmd_out),
    .final_trip_out(final_trip_out), .blocked_out(blocked_out),
    .in_progress_out(in_progress_out), .irq_out(irq_out));

  ars_far_side i_ars_far_side (
    .ref_clk_in(ref_clk_in), .pick_req_in(pick_req),
    .trip_req_in(trip_req), .earth_req_in(earth_req), .stuck_in(stuck),
    .slow_in(slow), .close_cmd_in(close_cmd_out), .pickup_out(pick_w),
    .trip_out(trip_w), .breaker_open_out(brk_w), .earth_out(earth_w));

  initial begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end

  task automatic wrap_up;
    $display("checked %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  // Counts cycles with final trip or close high, so that a missed or extra pulse shows; also cuts a hang.
  always @(posedge ref_clk_in) begin
    cyc++;
    if (final_trip_out === 1'b1) n_final++;
    if (close_cmd_out === 1'b1) n_close++;
    if (cyc == 30000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic chk_rng(input int got, input int lo, input int hi,
                         input string m);
    checked++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("wrong value at %0t: %s %0d not in %0d..%0d",
               $time, m, got, lo, hi);
    end
  endtask : chk_rng

  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_step

  function automatic logic [31:0] ctrl_word(input logic src, input logic mon,
                                            input logic [1:0] last);
    return {26'h0, last, 2'b01, mon, src};
  endfunction : ctrl_word

  // Address and reset value of each register but the interrupt status, then a hole and the status.
  function automatic logic [39:0] reg_rst(input int i);
    case (i)
      0:       return {8'h00, 32'h0000_0035};
      1:       return {8'h04, 32'h0000_01F4};
      2:       return {8'h08, 32'h0000_0064};
      3:       return {8'h0C, 32'h0000_07D0};
      12:      return {8'h48, 32'h0000_0000};
      13:      return {8'h10, 32'h0000_0000};
      14:      return {8'h40, 32'h0000_0000};
      default: return {8'h20 + 8'(4 * (i - 4)), 32'h0000_01F4};
    endcase
  endfunction : reg_rst

  function automatic logic sig(input int w);
    return (w == 0) ? close_cmd_out : (w == 1) ? in_progress_out : blocked_out;
  endfunction : sig

  // Every task but trip_pulse returns at a falling edge; drivers first wait a rising one.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    {addr_in, wdata_in, wr_in} <= {a, d, 1'b1};
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
    @(negedge ref_clk_in);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_in);
    {addr_in, rd_in} <= {a, 1'b1};
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    @(negedge ref_clk_in);
    d = rdata_out;
  endtask : rd

  task automatic wait_for(input int w, input logic lvl, input int lim);
    n = 0;
    do begin
      @(negedge ref_clk_in);
      n++;
    end while (sig(w) !== lvl && n < lim);
  endtask : wait_for

  task automatic idle(input int k);
    repeat (k) @(negedge ref_clk_in);
  endtask : idle

  task automatic trip_pulse(input int hold, input logic e);
    @(posedge ref_clk_in);
    {trip_req, pick_req, earth_req} <= {2'b10, e};
    wait_for(1, 1'b1, 40);
    chk_rng(n, 1, 12, "in progress after trip");
    idle(hold);
    @(posedge ref_clk_in);
    trip_req <= 1'b0;
  endtask : trip_pulse

  // One fault on shot s; returns as the close command rises.
  task automatic reclose(input int s, input logic e);
    lfsr = lfsr_step(lfsr);
    trip_pulse(4 + int'(lfsr[2:0]), e);
    wait_for(0, 1'b1, 400);
    chk_rng(n, (dt[2*s+e] - 1) * T, (dt[2*s+e] + 1) * T + 12,
            "dead");
  endtask : reclose

  initial begin
    {rst_in, wr_in, rd_in, addr_in, wdata_in} = {1'b1, 42'h0};
    {pick_req, trip_req, earth_req, stuck, slow} = 5'h0;
    lfsr = 32'h0000_1499;
    repeat (10) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    @(negedge ref_clk_in);
    chk({close_cmd_out, final_trip_out, blocked_out, in_progress_out,
         irq_out}, 32'h0, "outputs after reset");
    wr(8'h10, lfsr);
    for (int i = 0; i < 15; i++) begin
      rd(reg_rst(i)[39:32], rd_v);
      chk(rd_v, reg_rst(i)[31:0], "reset value");
    end
    $display("test registers done");
    // Short timers keep the run brief; dead times sit three to five ticks apart so
    // that a wrong shot or fault type cannot fall in the same window.
    wr(8'h04, 32'h6);
    wr(8'h08, C);
    wr(8'h48, 32'hF);
    wr(8'h00, ctrl_word(1'b0, 1'b0, 2'b01));
    for (int i = 0; i < 8; i++) begin
      lfsr = lfsr_step(lfsr);
      dt[i] = 4 * i + 2 + int'(lfsr[0]);
      wr(8'h20 + 8'(4 * i), dt[i]);
    end
    // A quiet reclaim, long and then shorter than the close pulse.
    for (int k = 0; k < 2; k++) begin
      r = k ? 1 : 10;
      wr(8'h0C, r);
      reclose(0, lfsr[3]);
      wait_for(1, 1'b0, 200);
      r = (r > C) ? r : C;
      chk_rng(n, (r - 1) * T, (r + 1) * T + 6, "reclaim end");
      chk(irq_out, 1'b1, "irq on success");
      rd(8'h44, rd_v);
      chk(rd_v, 32'h9, "irq status");
      wr(8'h44, 32'hF);
      chk(irq_out, 1'b0, "irq cleared");
    end
    $display("test success done");
    // Faults in reclaim walk both shots, then the last one is final.
    wr(8'h0C, 32'hA);
    reclose(0, lfsr[4]);
    wait_for(0, 1'b0, 80);
    chk_rng(n, (C - 1) * T, (C + 1) * T + 2, "close width");
    reclose(1, lfsr[5]);
    idle(C * T + 8);
    f0 = n_final;
    trip_pulse(4, 1'b0);
    wait_for(2, 1'b1, 40);
    chk(n_final - f0, 32'h1, "final after last shot");
    wr(8'h48, 32'h0);
    chk(irq_out, 1'b0, "irq masked");
    wr(8'h48, 32'h2);
    chk(irq_out, 1'b1, "irq final bit");
    wr(8'h44, 32'hF);
    wr(8'h48, 32'hF);
    wait_for(2, 1'b0, 200);
    $display("test final done");
    // A fault inside a long dead time ends without any close.
    dt[0] = 20;
    wr(8'h20, dt[0]);
    {f0, c0} = {n_final, n_close};
    trip_pulse(6, 1'b0);
    idle(40);
    trip_pulse(4, 1'b0);
    wait_for(2, 1'b1, 60);
    chk(n_final - f0, 32'h1, "final in dead time");
    chk(n_close - c0, 32'h0, "no close");
    wait_for(2, 1'b0, 200);
    // Pickup with no trip runs out the action time.
    @(posedge ref_clk_in);
    pick_req <= 1'b1;
    wait_for(2, 1'b1, 100);
    chk_rng(n, 5 * T, 7 * T + 8, "action timeout");
    chk(in_progress_out, 1'b0, "no sequence");
    @(posedge ref_clk_in);
    pick_req <= 1'b0;
    wait_for(2, 1'b0, 200);
    // Pickup in reclaim keeps the sequence for a late trip.
    wr(8'h04, 32'h28);
    reclose(0, 1'b0);
    @(posedge ref_clk_in);
    pick_req <= 1'b1;
    idle(12 * T);
    chk(in_progress_out, 1'b1, "held by pickup");
    reclose(1, 1'b1);
    wait_for(1, 1'b0, 200);
    $display("test pickup done");
    // Breaker left open after a final trip, with monitoring on and off.
    for (int m = 1; m >= 0; m--) begin
      wr(8'h00, ctrl_word(1'b1, m[0], 2'b00));
      @(posedge ref_clk_in);
      {stuck, slow} <= {1'b1, m[0]};
      reclose(0, 1'b0);
      idle(C * T + 8);
      trip_pulse(4, 1'b0);
      idle(13 * T);
      chk(blocked_out, m[0], "blocked after reclaim");
      if (m == 1) begin
        rd(8'h40, rd_v);
        chk(rd_v[3:0], 32'h8, "not ready");
        @(posedge ref_clk_in);
        trip_req <= 1'b1;
        idle(20);
        chk({blocked_out, in_progress_out}, 32'h2, "trip ignored");
        @(posedge ref_clk_in);
        trip_req <= 1'b0;
        idle(10);
      end
      @(posedge ref_clk_in);
      stuck <= 1'b0;
      wait_for(2, 1'b0, 100);
      chk(blocked_out, 1'b0, "breaker closed");
    end
    $display("test not ready done");
    wrap_up();
  end
endmodule : ars_sequencer_test
